// ===== pdlc_consts.svh
`ifndef PDLC_CONSTS_SVH
`define PDLC_CONSTS_SVH

// ==========================================================
// register byte offsets
`define PDLC_OFS_DEVCAP 8'h6C
`define PDLC_OFS_DEVSC 8'h70
`define PDLC_OFS_LNKCAP 8'h74

// ==========================================================
// field positions
`define PDLC_BIT_RBER 15
`define PDLC_BIT_RO_EN 4
`define PDLC_BIT_NS_EN 11
`define PDLC_LSB_MPS 5
`define PDLC_LSB_STS 16

// ==========================================================
// reset values and codes
`define PDLC_RST_ERR_EN 4'h0
`define PDLC_RST_RO_EN 1'b1
`define PDLC_RST_NS_EN 1'b1
`define PDLC_RST_MPS 3'h0
`define PDLC_MPS_MAX_CODE 3'h4
`define PDLC_SPEED_GEN3 4'h3
`define PDLC_SPEED_GEN2 4'h2
`define PDLC_SPEED_GEN1 4'h1
`define PDLC_RST_ASPM 2'h3
`define PDLC_RST_L0S_LAT 3'h6
`define PDLC_RST_L1_LAT 3'h2
`define PDLC_WIDTH_X16 6'h10
`define PDLC_WIDTH_X8 6'h08
`define PDLC_WIDTH_X4 6'h04
`define PDLC_WIDTH_X2 6'h02
`define PDLC_MPS_SUP_2K 3'h4
`define PDLC_MPS_SUP_1K 3'h3
`define PDLC_MPS_SUP_512 3'h2
`define PDLC_PAYLOAD_BASE 12'h080

// ==========================================================
// timing
`define PDLC_SYNC_STAGES 2

`endif

// ===== pdlc_host.sv
`timescale 1ns/1ns
// ==========================================================
// host configuration master, classic wishbone single cycles
module pdlc_host (
  input wire logic clk_i,
  input wire logic ack_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // advertised payload capability as last read by software
  logic [2:0] mps_cap = 3'h4;

  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end

  // request held until the edge that samples ack high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] v;
    v = d;
    if (w && a == 8'h70 && s[0] && v[7:5] > mps_cap) begin
      v[7:5] = mps_cap;
    end
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'h3, w, a, s, v};
    @(posedge clk_i);
    while (ack_i !== 1'b1) begin
      @(posedge clk_i);
    end
    {cyc_o, stb_o, we_o} <= 3'h0;
  endtask : xfer
endmodule : pdlc_host

// ===== pdlc_pkg.sv
package pdlc_pkg;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    PDLC_ST_LOAD = 2'b01,
    PDLC_ST_RUN = 2'b10
  } pdlc_state_e;

  typedef struct packed {
    logic [2:0] mps_sup;
    logic [7:0] spl_val;
    logic [1:0] spl_scale;
  } pdlc_devcap_s;

  typedef struct packed {
    logic [3:0] err_en;
    logic ro_en;
    logic [2:0] mps;
    logic ns_en;
  } pdlc_devctl_s;

  typedef struct packed {
    logic [3:0] speed;
    logic [5:0] width;
    logic [1:0] aspm;
    logic [2:0] l0s_lat;
    logic [2:0] l1_lat;
    logic clkpm;
    logic sdrc;
    logic dllar;
    logic lbn;
  } pdlc_linkcap_s;

  typedef struct packed {
    logic [1:0] speed;
    logic [1:0] layout;
    logic upstream;
  } pdlc_strap_s;

endpackage : pdlc_pkg

// ===== pdlc_regs.sv
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ns
`include "pdlc_consts.svh"

// Functional notes
// - role-based error reporting bit fixed one
// - four error reporting enables, reset zero
// - relaxed ordering, no snoop: writable, reset one
// - payload size field, codes 0..4, reset zero
// - unsupported control bits read zero, ignore writes
// - error status bits set always, write-one clears
// - status bits 20 and up read zero
// - max link speed default gen3 code
// - speed strap lowers speed default
// - power management support defaults both states
// - L0s exit latency defaults 110b
// - L1 exit latency defaults 010b
// - clock power management bit reads zero on downstream ports, loader can set it on upstream
// - surprise-down capable gates status enable
// - link active reporting downstream only
// - bandwidth notification downstream only
module pdlc_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] speed_limit_strap_i,
  input wire logic [1:0] station_port_layout_strap_i,
  input wire logic port_upstream_strap_i,
  input wire logic ld_stb_i,
  input wire logic [7:0] ld_adr_i,
  input wire logic [31:0] ld_dat_i,
  input wire logic ld_done_i,
  input wire logic [3:0] err_event_i,
  output logic [3:0] err_report_o,
  output logic [11:0] payload_limit_o,
  output logic [7:0] slot_power_value_o,
  output logic [1:0] slot_power_scale_o,
  output logic surprise_down_en_o,
  output logic config_ready_o
);

  // ==========================================================
  // strap synchronisers
  pdlc_pkg::pdlc_strap_s strap_raw;
  pdlc_pkg::pdlc_strap_s strap;
  assign strap_raw = '{speed: speed_limit_strap_i, layout: station_port_layout_strap_i,
                       upstream: port_upstream_strap_i};

  pdlc_sync #(.W(5)) u_sync (
    .clk_i(clk_i),
    .async_i(strap_raw),
    .sync_o(strap)
  );

  // strap decode; bit1 of speed strap flags a floating pin, bit0 its level
  logic [3:0] speed_dflt;
  logic [5:0] width_dflt;
  logic [2:0] mps_sup_dflt;
  always_comb begin
    if (strap.speed[1]) begin
      speed_dflt = `PDLC_SPEED_GEN2;
    end else if (!strap.speed[0]) begin
      speed_dflt = `PDLC_SPEED_GEN1;
    end else begin
      speed_dflt = `PDLC_SPEED_GEN3;
    end
    case (strap.layout)
      2'h0: begin
        width_dflt = `PDLC_WIDTH_X16;
        mps_sup_dflt = `PDLC_MPS_SUP_2K;
      end
      2'h1: begin
        width_dflt = `PDLC_WIDTH_X8;
        mps_sup_dflt = `PDLC_MPS_SUP_2K;
      end
      2'h2: begin
        width_dflt = `PDLC_WIDTH_X4;
        mps_sup_dflt = `PDLC_MPS_SUP_1K;
      end
      default: begin
        width_dflt = `PDLC_WIDTH_X2;
        mps_sup_dflt = `PDLC_MPS_SUP_512;
      end
    endcase
  end

  // ==========================================================
  // wishbone slave: ack one cycle after the request, held off while loading
  pdlc_pkg::pdlc_state_e state_q, state_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic up_q, up_d;
  logic wb_req;
  logic wb_wr;
  logic [31:0] rd_word;
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr = wb_req && wb_we_i && ack_q;

  always_comb begin
    state_d = state_q;
    up_d = up_q;
    case (state_q)
      pdlc_pkg::PDLC_ST_LOAD: begin
        if (ld_done_i) begin
          state_d = pdlc_pkg::PDLC_ST_RUN;
        end
      end
      pdlc_pkg::PDLC_ST_RUN: state_d = pdlc_pkg::PDLC_ST_RUN;
      default: state_d = pdlc_pkg::PDLC_ST_LOAD;
    endcase
    ack_d = wb_req && !ack_q && (state_q == pdlc_pkg::PDLC_ST_RUN) && !rst_i;
    dat_d = dat_q;
    if (ack_d) begin
      dat_d = wb_we_i ? 32'h0000_0000 : rd_word;
    end
    if (rst_i) begin
      state_d = pdlc_pkg::PDLC_ST_LOAD;
      up_d = strap.upstream;
      dat_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    state_q <= state_d;
    ack_q <= ack_d;
    dat_q <= dat_d;
    up_q <= up_d;
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign config_ready_o = (state_q == pdlc_pkg::PDLC_ST_RUN);

  // ==========================================================
  // register state
  pdlc_pkg::pdlc_devcap_s cap_q, cap_d;
  pdlc_pkg::pdlc_devctl_s ctl_q, ctl_d;
  pdlc_pkg::pdlc_linkcap_s lnk_q, lnk_d;
  logic [3:0] sts_q, sts_d;
  logic [3:0] sts_clr;
  logic ld_wr;
  assign ld_wr = ld_stb_i && (state_q == pdlc_pkg::PDLC_ST_LOAD);

  always_comb begin
    cap_d = cap_q;
    ctl_d = ctl_q;
    lnk_d = lnk_q;
    sts_clr = 4'h0;
    if (ld_wr) begin
      case (ld_adr_i)
        `PDLC_OFS_DEVCAP: begin
          cap_d.mps_sup = ld_dat_i[2:0];
          cap_d.spl_val = ld_dat_i[25:18];
          cap_d.spl_scale = ld_dat_i[27:26];
        end
        `PDLC_OFS_DEVSC: begin
          ctl_d.err_en = ld_dat_i[3:0];
          ctl_d.ro_en = ld_dat_i[`PDLC_BIT_RO_EN];
          ctl_d.ns_en = ld_dat_i[`PDLC_BIT_NS_EN];
          if (ld_dat_i[7:5] <= `PDLC_MPS_MAX_CODE) begin
            ctl_d.mps = ld_dat_i[7:5];
          end
        end
        `PDLC_OFS_LNKCAP: begin
          lnk_d.speed = ld_dat_i[3:0];
          lnk_d.width = ld_dat_i[9:4];
          lnk_d.aspm = ld_dat_i[11:10];
          lnk_d.l1_lat = ld_dat_i[17:15];
          lnk_d.clkpm = ld_dat_i[18] && up_q;
          lnk_d.sdrc = ld_dat_i[19];
          lnk_d.dllar = ld_dat_i[20];
          lnk_d.lbn = ld_dat_i[21];
        end
        default: cap_d = cap_q;
      endcase
    end
    if (wb_wr && (wb_adr_i == `PDLC_OFS_DEVSC)) begin
      if (wb_sel_i[0]) begin
        ctl_d.err_en = wb_dat_i[3:0];
        ctl_d.ro_en = wb_dat_i[`PDLC_BIT_RO_EN];
        // unsupported codes are dropped so the payload limit stays meaningful
        if (wb_dat_i[7:5] <= `PDLC_MPS_MAX_CODE) begin
          ctl_d.mps = wb_dat_i[7:5];
        end
      end
      if (wb_sel_i[1]) begin
        ctl_d.ns_en = wb_dat_i[`PDLC_BIT_NS_EN];
      end
      if (wb_sel_i[2]) begin
        sts_clr = wb_dat_i[19:16];
      end
    end
    // a new event in the clearing cycle keeps its flag
    sts_d = (sts_q & ~sts_clr) | err_event_i;
    if (rst_i) begin
      cap_d = '{mps_sup: mps_sup_dflt, spl_val: 8'h00, spl_scale: 2'h0};
      ctl_d = '{err_en: `PDLC_RST_ERR_EN, ro_en: `PDLC_RST_RO_EN, mps: `PDLC_RST_MPS,
                ns_en: `PDLC_RST_NS_EN};
      lnk_d = '{speed: speed_dflt, width: width_dflt, aspm: `PDLC_RST_ASPM,
                l0s_lat: `PDLC_RST_L0S_LAT, l1_lat: `PDLC_RST_L1_LAT, clkpm: 1'b0,
                sdrc: 1'b1, dllar: 1'b1, lbn: 1'b1};
      sts_d = 4'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    cap_q <= cap_d;
    ctl_q <= ctl_d;
    lnk_q <= lnk_d;
    sts_q <= sts_d;
  end

  // ==========================================================
  // read words; role gates fields that exist on one side only
  logic [31:0] devcap_word, devsc_word, lnkcap_word;
  always_comb begin
    devcap_word = 32'h0000_0000;
    devcap_word[2:0] = cap_q.mps_sup;
    devcap_word[`PDLC_BIT_RBER] = 1'b1;
    if (up_q) begin
      devcap_word[25:18] = cap_q.spl_val;
      devcap_word[27:26] = cap_q.spl_scale;
    end
    devsc_word = 32'h0000_0000;
    devsc_word[3:0] = ctl_q.err_en;
    devsc_word[`PDLC_BIT_RO_EN] = ctl_q.ro_en;
    devsc_word[7:5] = ctl_q.mps;
    devsc_word[`PDLC_BIT_NS_EN] = ctl_q.ns_en;
    devsc_word[19:16] = sts_q;
    lnkcap_word = 32'h0000_0000;
    lnkcap_word[3:0] = lnk_q.speed;
    lnkcap_word[9:4] = lnk_q.width;
    lnkcap_word[11:10] = lnk_q.aspm;
    lnkcap_word[14:12] = lnk_q.l0s_lat;
    lnkcap_word[17:15] = lnk_q.l1_lat;
    lnkcap_word[18] = lnk_q.clkpm && up_q;
    lnkcap_word[19] = lnk_q.sdrc && !up_q;
    lnkcap_word[20] = lnk_q.dllar && !up_q;
    lnkcap_word[21] = lnk_q.lbn && !up_q;
    case (wb_adr_i)
      `PDLC_OFS_DEVCAP: rd_word = devcap_word;
      `PDLC_OFS_DEVSC: rd_word = devsc_word;
      `PDLC_OFS_LNKCAP: rd_word = lnkcap_word;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // outputs to the port logic
  logic [3:0] rep_q, rep_d;
  logic [11:0] pay_q, pay_d;
  logic [7:0] spv_q, spv_d;
  logic [1:0] sps_q, sps_d;
  logic sde_q, sde_d;
  always_comb begin
    rep_d = err_event_i & ctl_q.err_en;
    pay_d = `PDLC_PAYLOAD_BASE << ctl_q.mps;
    spv_d = up_q ? cap_q.spl_val : 8'h00;
    sps_d = up_q ? cap_q.spl_scale : 2'h0;
    sde_d = lnk_q.sdrc && !up_q;
    if (rst_i) begin
      rep_d = 4'h0;
      pay_d = `PDLC_PAYLOAD_BASE;
      spv_d = 8'h00;
      sps_d = 2'h0;
      sde_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    rep_q <= rep_d;
    pay_q <= pay_d;
    spv_q <= spv_d;
    sps_q <= sps_d;
    sde_q <= sde_d;
  end

  assign err_report_o = rep_q;
  assign payload_limit_o = pay_q;
  assign slot_power_value_o = spv_q;
  assign slot_power_scale_o = sps_q;
  assign surprise_down_en_o = sde_q;

  // ==========================================================
  // assertions
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  AST_ACK_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(wb_ack_o) |-> s_ack_pulse)
    else $error("ack held longer than one cycle");
  AST_NO_ACK_LOADING: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == pdlc_pkg::PDLC_ST_LOAD) |=> !wb_ack_o)
    else $error("ack given while loader active");
  AST_STS_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    err_event_i[0] |=> sts_q[0])
    else $error("correctable status not set by event");
  AST_STS_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (sts_q[2] && !(wb_wr && wb_sel_i[2] && wb_dat_i[18] && (wb_adr_i == `PDLC_OFS_DEVSC))) |=> sts_q[2])
    else $error("fatal status lost without write one");
  AST_REPORT_GATED: assert property (@(posedge clk_i) disable iff (rst_i)
    err_report_o[1] |-> ($past(err_event_i[1]) && $past(ctl_q.err_en[1])))
    else $error("non-fatal reported while disabled");
  AST_MPS_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_q.mps <= `PDLC_MPS_MAX_CODE)
    else $error("payload code out of range");
  AST_RD_DEVCAP: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_d && !wb_we_i && (wb_adr_i == `PDLC_OFS_DEVCAP)) |=> (wb_dat_o[15] && (wb_dat_o[31:28] == 4'h0)))
    else $error("role-based bit or reserved bits wrong");
  AST_RD_DEVSC_RSVD: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_d && !wb_we_i && (wb_adr_i == `PDLC_OFS_DEVSC))
    |=> ((wb_dat_o[31:20] == 12'h000) && (wb_dat_o[15:12] == 4'h0)))
    else $error("reserved status or control bits not zero");
  AST_UP_LINK_BITS: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_d && !wb_we_i && up_q && (wb_adr_i == `PDLC_OFS_LNKCAP)) |=> (wb_dat_o[21:19] == 3'h0))
    else $error("downstream-only link bits set on upstream port");
  AST_DN_CLKPM: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_d && !wb_we_i && !up_q && (wb_adr_i == `PDLC_OFS_LNKCAP)) |=> !wb_dat_o[18])
    else $error("clock pm bit set on downstream port");
  AST_RESET_DFLT: assert property (@(posedge clk_i)
    $fell(rst_i) |-> ((lnk_q.l0s_lat == `PDLC_RST_L0S_LAT) && (lnk_q.l1_lat == `PDLC_RST_L1_LAT)
                      && ctl_q.ro_en && ctl_q.ns_en && (ctl_q.mps == `PDLC_RST_MPS)))
    else $error("reset defaults wrong");
  // the edge that releases reset still registers the reset value, so start one edge later
  AST_SDE: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (surprise_down_en_o == $past(lnk_q.sdrc && !up_q)))
    else $error("surprise-down enable does not follow capability");
endmodule : pdlc_regs

// ===== pdlc_sync.sv
`timescale 1ns/1ns
module pdlc_sync #(
  parameter int W = 5
) (
  input wire logic clk_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  // ==========================================================
  // two-stage synchroniser per bit
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_q;
      logic meta_d;
      logic sync_q;
      logic sync_d;
      always_comb begin
        meta_d = async_i[g];
        sync_d = meta_q;
      end
      always_ff @(posedge clk_i) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
      end
      assign sync_o[g] = sync_q;
    end
  endgenerate

endmodule : pdlc_sync

// ===== test_pcie_device_link_capability_regs.sv
`timescale 1ns/1ns
`define CHK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module test_pcie_device_link_capability_regs;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] spd_strap = 2'h0;
  logic [1:0] lay_strap = 2'h2;
  logic up_strap = 1'b0;
  logic ld_stb = 1'b0;
  logic [7:0] ld_adr = 8'h00;
  logic [31:0] ld_dat = 32'h0;
  logic ld_done = 1'b0;
  logic [3:0] err_ev = 4'h0;
  logic cyc, stb, we, ack, sd_en, cfg_rdy;
  logic [7:0] adr, spv;
  logic [3:0] sel, err_rep;
  logic [31:0] wdat, rdat, e_m;
  logic [11:0] pay_lim;
  logic [1:0] sps;
  int num_errors = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'hF6EA;
  logic [31:0] exp_q[$];

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  pdlc_host u_host (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat));

  pdlc_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .speed_limit_strap_i(spd_strap), .station_port_layout_strap_i(lay_strap),
    .port_upstream_strap_i(up_strap), .ld_stb_i(ld_stb), .ld_adr_i(ld_adr), .ld_dat_i(ld_dat),
    .ld_done_i(ld_done), .err_event_i(err_ev), .err_report_o(err_rep), .payload_limit_o(pay_lim),
    .slot_power_value_o(spv), .slot_power_scale_o(sps), .surprise_down_en_o(sd_en),
    .config_ready_o(cfg_rdy));

  // ==========================================================
  // read data checker: oldest expectation against each read ack
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      e_m = exp_q.pop_front();
      `CHK(rdat, e_m)
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, a, 4'hF, xs());
  endtask : rd

  task automatic load(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {ld_stb, ld_adr, ld_dat} <= {1'b1, a, d};
    @(posedge clk_i);
    ld_stb <= 1'b0;
  endtask : load

  task automatic summarize();
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    summarize();
  end

  // ==========================================================
  // main sequence: four strap setups, then control and status
  initial begin
    logic [31:0] lc, dc, v, d;
    for (int k = 3; k >= 0; k--) begin
      spd_strap <= (k == 0) ? 2'h1 : (k == 1) ? 2'h2 : (k == 3) ? 2'h3 : 2'h0;
      lay_strap <= 2'(k);
      up_strap <= (k == 1);
      // straps settle before reset so their defaults are captured
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      u_host.mps_cap = (k == 3) ? 3'h2 : (k == 2) ? 3'h3 : 3'h4;
      dc = {4'h0, 2'h0, 8'h00, 2'h0, 1'b1, 12'h000, u_host.mps_cap};
      lc = {10'h000, (k == 1) ? 3'h0 : 3'h7, 1'b0, 3'h2, 3'h6, 2'h3, 6'h10 >> k, (k == 3) ? 4'h2 : 4'(3 - k)};
      if (k == 1) begin
        v = xs();
        dc[27:18] = v[9:0];
        load(8'h6C, dc);
      end
      if (k == 2) begin
        lc[19] = 1'b0;
        load(8'h74, lc);
      end
      if (k == 3) begin
        // payload code 7 from the loader must be dropped, enables keep their values
        load(8'h70, 32'h0000_08F0);
      end
      @(negedge clk_i);
      `CHK(cfg_rdy, 1'b0)
      // the first read is issued while loading, so its ack must wait for the done pulse
      fork
        rd(8'h6C, dc);
        begin
          repeat ((k == 0) ? 4 : 1) @(posedge clk_i);
          ld_done <= 1'b1;
          @(posedge clk_i);
          ld_done <= 1'b0;
        end
      join
      rd(8'h74, lc);
      rd(8'h70, 32'h0000_0810);
      @(negedge clk_i);
      `CHK(spv, (k == 1) ? dc[25:18] : 8'h00)
      `CHK(sps, (k == 1) ? dc[27:26] : 2'h0)
      `CHK(sd_en, (k == 0) || (k == 3))
      `CHK(cfg_rdy, 1'b1)
      `CHK(pay_lim, 12'h080)
    end
    for (int c = 0; c < 5; c++) begin
      v = xs();
      v[7:5] = c[2:0];
      u_host.xfer(1'b1, 8'h70, 4'hF, v);
      rd(8'h70, v & 32'h0000_08FF);
      `CHK(pay_lim, 12'h080 << c)
    end
    @(posedge clk_i);
    err_ev <= 4'hF;
    @(posedge clk_i);
    err_ev <= 4'h0;
    @(negedge clk_i);
    `CHK(err_rep, v[3:0])
    @(negedge clk_i);
    `CHK(err_rep, 4'h0)
    rd(8'h70, {12'h000, 4'hF, v[15:0] & 16'h08FF});
    d = xs();
    d[19:16] = 4'h5;
    // only the status byte is enabled, other bytes must not move
    u_host.xfer(1'b1, 8'h70, 4'h4, d);
    rd(8'h70, {12'h000, 4'hA, v[15:0] & 16'h08FF});
    u_host.xfer(1'b1, 8'h6C, 4'hF, 32'hFFFF_FFFF);
    rd(8'h6C, dc);
    u_host.xfer(1'b1, 8'h74, 4'hF, 32'h0000_0000);
    rd(8'h74, lc);
    rd(8'h10, 32'h0000_0000);
    repeat (4) @(posedge clk_i);
    summarize();
  end
endmodule : test_pcie_device_link_capability_regs
